// file: hdl/hcf_pkg.sv
/*
 Shared constants for the host operating-control block: register map,
 field positions, functional-state encoding and timing figures.
 Assumes a 250 MHz core clock and a 32-bit AXI4-Lite register bus.
*/
package hcf_pkg;

   // -------------------------------------------------------------
   // timing
   // -------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 4;
   localparam int SOF_DELAY_NS = 1000000;
   // least time, rounded up to whole cycles
   localparam int SOF_DELAY_CYC =
      (SOF_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [7:0] HUB_RST_CYC = 8'h10;

   // -------------------------------------------------------------
   // register port codes and byte addresses
   // -------------------------------------------------------------
   localparam logic [7:0] CTRL_RD_CODE = 8'h01;
   localparam logic [7:0] CTRL_WR_CODE = 8'h81;
   // write code carries the same index in its low bits
   localparam logic [7:0] ADDR_CTRL = {CTRL_RD_CODE[5:0], 2'h0};
   localparam logic [7:0] ADDR_INTSTS = 8'h10;
   localparam logic [7:0] ADDR_INTMASK = 8'h14;
   localparam logic [7:0] ADDR_SWRST = 8'h18;
   localparam logic [7:0] ADDR_STATUS = 8'h1C;

   // -------------------------------------------------------------
   // field positions
   // -------------------------------------------------------------
   localparam int RWE_BIT = 10;
   localparam int RWC_BIT = 9;
   localparam int FS_MSB = 7;
   localparam int FS_LSB = 6;
   localparam logic [31:0] CTRL_MASK = 32'h000006C0;
   localparam int INT_W = 2;
   localparam int INT_RD_BIT = 0;
   localparam int INT_SF_BIT = 1;
   localparam int SWRST_BIT = 0;
   localparam int ST_SOF_BIT = 0;
   localparam int ST_WAKE_BIT = 1;
   localparam int ST_HUB_BIT = 2;

   // -------------------------------------------------------------
   // encodings
   // -------------------------------------------------------------
   typedef enum logic [1:0] {
      FS_BUS_RESET = 2'h0,
      FS_BUS_RESUME = 2'h1,
      FS_OPERATIONAL = 2'h2,
      FS_SUSPENDED = 2'h3
   } hcf_fs_e;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// file: hdl/hcf_sticky.sv
/*
 One sticky event bit: hardware sets it, software clears it by writing
 a one. Assumes set and clear arrive as single-cycle terms.
*/
`timescale 1ns/1ns
`default_nettype none
module hcf_sticky
(
   input wire logic clk,   // core clock
   input wire logic nrst,  // async reset, active low
   input wire logic set,   // event pulse
   input wire logic clr,   // write-one-to-clear
   output logic q          // sticky flag
);

   logic q_r;
   logic q_nxt;

   // set wins over a clear in the same cycle
   always_comb
   begin
      q_nxt = set | (q_r & ~clr);
   end

   // flag storage
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         q_r <= 1'b0;
      else
         q_r <= q_nxt;
   end

   assign q = q_r;

   chk_set_wins: assert property (@(posedge clk) disable iff (!nrst)
      set |=> q_r)
      else $error("sticky flag lost an event");

endmodule
`default_nettype wire

// file: hdl/hcf_sof_timer.sv
/*
 Delay timer for frame-start generation: a start pulse loads the count,
 a one-cycle done pulse follows exactly DELAY_CYC cycles later.
 Assumes stop is held while the bus is not operational.
*/
`timescale 1ns/1ns
`default_nettype none
module hcf_sof_timer
#(
   parameter int DELAY_CYC = 250000,
   parameter int CNT_W = 18
)
(
   input wire logic clk,   // core clock
   input wire logic nrst,  // async reset, active low
   input wire logic start, // begin the delay
   input wire logic stop,  // abandon the delay
   output logic done       // delay elapsed, one cycle
);

   logic [CNT_W-1:0] count_r;
   logic busy_r;
   logic done_r;

   // down-counter with stop over start over expiry
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         count_r <= '0;
         busy_r <= 1'b0;
         done_r <= 1'b0;
      end
      else if (stop)
      begin
         busy_r <= 1'b0;
         done_r <= 1'b0;
      end
      else if (start)
      begin
         count_r <= CNT_W'(DELAY_CYC - 1);
         busy_r <= 1'b1;
         done_r <= 1'b0;
      end
      else if (busy_r && count_r == '0)
      begin
         busy_r <= 1'b0;
         done_r <= 1'b1;
      end
      else
      begin
         count_r <= busy_r ? count_r - 1'b1 : count_r;
         done_r <= 1'b0;
      end
   end

   assign done = done_r;

   chk_done_single: assert property (@(posedge clk) disable iff (!nrst)
      done_r |=> !done_r)
      else $error("timer done pulse longer than one cycle");

endmodule
`default_nettype wire

// file: hdl/hcf_top.sv
/*
 Host operating-control register block behind an AXI4-Lite slave:
 functional state, remote wake-up bits, frame-start delay, sticky
 event status with mask and interrupt, root hub reset after power-up.
 Assumes resumeDetect is a synchronous pulse from the downstream ports.
*/
`timescale 1ns/1ns
`default_nettype none
module hcf_top
   import hcf_pkg::*;
#(
   parameter int SOF_CYC = SOF_DELAY_CYC,
   parameter int CNT_W = $clog2(SOF_CYC + 2)
)
(
   input wire logic clk,          // 250 MHz core clock
   input wire logic nrst,         // async reset, active low
   input wire logic [7:0] awaddr, // write address
   input wire logic awvalid,      // write address valid
   output logic awready,          // write address ready
   input wire logic [31:0] wdata, // write data
   input wire logic [3:0] wstrb,  // write byte enables
   input wire logic wvalid,       // write data valid
   output logic wready,           // write data ready
   output logic [1:0] bresp,      // write response
   output logic bvalid,           // write response valid
   input wire logic bready,       // write response ready
   input wire logic [7:0] araddr, // read address
   input wire logic arvalid,      // read address valid
   output logic arready,          // read address ready
   output logic [31:0] rdata,     // read data
   output logic [1:0] rresp,      // read response
   output logic rvalid,           // read data valid
   input wire logic rready,       // read data ready
   input wire logic resumeDetect, // resume seen on a port
   output logic irq,              // level interrupt
   output logic remoteWakeup,     // wake-up to host system
   output logic sofActive,        // frame starts running
   output logic rootHubReset,     // root hub held in reset
   output logic portResetDrive    // reset signalling on ports
);

   // -------------------------------------------------------------
   // declarations
   // -------------------------------------------------------------
   logic awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
   logic awHeld_r, wHeld_r;
   logic [7:0] awAddr_r;
   logic [31:0] wData_r;
   logic [3:0] wStrb_r;
   logic [1:0] bresp_r, rresp_r;
   logic [31:0] rdata_r;
   logic doWrite, ctrlWr, swRst, wrMapped;
   logic [INT_W-1:0] stsClr, stsSet, intSts;
   logic [INT_W-1:0] mask_r;
   hcf_fs_e fs_r, fsPrev_r;
   logic rwe_r, rwc_r;
   logic enterOper, sofDone, sofActive_r;
   logic irq_r, wake_r;
   logic [7:0] hubCnt_r;
   logic hubRst_r;
   logic [31:0] rdWord;
   logic rdMapped;
   logic [CNT_W:0] operCnt_r;

   // -------------------------------------------------------------
   // write channel
   // -------------------------------------------------------------
   assign doWrite = awHeld_r && wHeld_r && !bvalid_r;

   // address and data taken in either order
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         awHeld_r <= 1'b0;
         awready_r <= 1'b1;
         awAddr_r <= 8'h00;
      end
      else if (awvalid && awready_r)
      begin
         awHeld_r <= 1'b1;
         awready_r <= 1'b0;
         awAddr_r <= awaddr;
      end
      else if (doWrite)
      begin
         awHeld_r <= 1'b0;
         awready_r <= 1'b1;
      end
   end

   // write data holding
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         wHeld_r <= 1'b0;
         wready_r <= 1'b1;
         wData_r <= 32'h00000000;
         wStrb_r <= 4'h0;
      end
      else if (wvalid && wready_r)
      begin
         wHeld_r <= 1'b1;
         wready_r <= 1'b0;
         wData_r <= wdata;
         wStrb_r <= wstrb;
      end
      else if (doWrite)
      begin
         wHeld_r <= 1'b0;
         wready_r <= 1'b1;
      end
   end

   // write decode
   always_comb
   begin
      wrMapped = awAddr_r == ADDR_CTRL || awAddr_r == ADDR_INTSTS ||
         awAddr_r == ADDR_INTMASK || awAddr_r == ADDR_SWRST ||
         awAddr_r == ADDR_STATUS;
      ctrlWr = doWrite && awAddr_r == ADDR_CTRL;
      swRst = doWrite && awAddr_r == ADDR_SWRST && wStrb_r[0] &&
         wData_r[SWRST_BIT];
      stsClr = (doWrite && awAddr_r == ADDR_INTSTS && wStrb_r[0]) ?
         wData_r[INT_W-1:0] : '0;
   end

   // write response
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         bvalid_r <= 1'b0;
         bresp_r <= RESP_OKAY;
      end
      else if (doWrite)
      begin
         bvalid_r <= 1'b1;
         bresp_r <= wrMapped ? RESP_OKAY : RESP_SLVERR;
      end
      else if (bready)
         bvalid_r <= 1'b0;
   end

   // -------------------------------------------------------------
   // control register fields
   // -------------------------------------------------------------
   // functional state: software write, reset, or autonomous resume
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         fs_r <= FS_BUS_RESET;
      else if (swRst)
         fs_r <= FS_BUS_RESET;
      else if (ctrlWr && wStrb_r[0])
         fs_r <= hcf_fs_e'(wData_r[FS_MSB:FS_LSB]);
      else if (fs_r == FS_SUSPENDED && resumeDetect)
         fs_r <= FS_BUS_RESUME;
   end

   // wake-up enable written by software only, cleared by resets
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         rwe_r <= 1'b0;
      else if (swRst)
         rwe_r <= 1'b0;
      else if (ctrlWr && wStrb_r[1])
         rwe_r <= wData_r[RWE_BIT];
   end

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         rwc_r <= 1'b0;
      else if (ctrlWr && wStrb_r[1])
         rwc_r <= wData_r[RWC_BIT];
   end

   // -------------------------------------------------------------
   // frame-start delay
   // -------------------------------------------------------------
   // detect entry to operational
   assign enterOper = fs_r == FS_OPERATIONAL &&
      fsPrev_r != FS_OPERATIONAL;

   // previous state for transition detection
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         fsPrev_r <= FS_BUS_RESET;
      else
         fsPrev_r <= fs_r;
   end

   // entry detect and the output flop each add a cycle, so the
   // timer runs two short and frames begin exactly SOF_CYC later
   hcf_sof_timer #(
      .DELAY_CYC(SOF_CYC - 2),
      .CNT_W(CNT_W)
   ) u_sof_timer (
      .clk(clk),
      .nrst(nrst),
      .start(enterOper),
      .stop(fs_r != FS_OPERATIONAL),
      .done(sofDone)
   );

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         sofActive_r <= 1'b0;
      else if (fs_r != FS_OPERATIONAL)
         sofActive_r <= 1'b0;
      else if (sofDone)
         sofActive_r <= 1'b1;
   end

   // -------------------------------------------------------------
   // event status, mask and interrupt
   // -------------------------------------------------------------
   // event sources
   always_comb
   begin
      stsSet = '0;
      stsSet[INT_RD_BIT] = resumeDetect;
      stsSet[INT_SF_BIT] = sofDone;
   end

   genvar gi;
   generate
      for (gi = 0; gi < INT_W; gi++)
      begin : g_sts
         hcf_sticky u_sticky (
            .clk(clk),
            .nrst(nrst),
            .set(stsSet[gi]),
            .clr(stsClr[gi]),
            .q(intSts[gi])
         );
      end
   endgenerate

   // interrupt mask
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         mask_r <= '0;
      else if (doWrite && awAddr_r == ADDR_INTMASK && wStrb_r[0])
         mask_r <= wData_r[INT_W-1:0];
   end

   // interrupt and wake-up outputs
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         irq_r <= 1'b0;
         wake_r <= 1'b0;
      end
      else
      begin
         irq_r <= |(intSts & mask_r);
         wake_r <= rwe_r && intSts[INT_RD_BIT];
      end
   end

   // -------------------------------------------------------------
   // root hub reset after hardware reset
   // -------------------------------------------------------------
   // hardware reset only
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         hubCnt_r <= HUB_RST_CYC;
         hubRst_r <= 1'b1;
      end
      else if (hubCnt_r != 8'h00)
         hubCnt_r <= hubCnt_r - 8'h01;
      else
         hubRst_r <= 1'b0;
   end

   // -------------------------------------------------------------
   // read channel
   // -------------------------------------------------------------
   // read mux, reserved bits zero
   always_comb
   begin
      rdWord = 32'h00000000;
      rdMapped = 1'b1;
      case (araddr)
         ADDR_CTRL:
         begin
            rdWord[RWE_BIT] = rwe_r;
            rdWord[RWC_BIT] = rwc_r;
            rdWord[FS_MSB:FS_LSB] = fs_r;
         end
         ADDR_INTSTS: rdWord[INT_W-1:0] = intSts;
         ADDR_INTMASK: rdWord[INT_W-1:0] = mask_r;
         ADDR_SWRST: rdWord = 32'h00000000;
         ADDR_STATUS:
         begin
            rdWord[ST_SOF_BIT] = sofActive_r;
            rdWord[ST_WAKE_BIT] = wake_r;
            rdWord[ST_HUB_BIT] = hubRst_r;
         end
         default: rdMapped = 1'b0;
      endcase
   end

   // read handshake
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         arready_r <= 1'b1;
         rvalid_r <= 1'b0;
         rdata_r <= 32'h00000000;
         rresp_r <= RESP_OKAY;
      end
      else if (arvalid && arready_r)
      begin
         arready_r <= 1'b0;
         rvalid_r <= 1'b1;
         rdata_r <= rdWord;
         rresp_r <= rdMapped ? RESP_OKAY : RESP_SLVERR;
      end
      else if (rvalid_r && rready)
      begin
         arready_r <= 1'b1;
         rvalid_r <= 1'b0;
      end
   end

   // -------------------------------------------------------------
   // outputs
   // -------------------------------------------------------------
   assign awready = awready_r;
   assign wready = wready_r;
   assign bvalid = bvalid_r;
   assign bresp = bresp_r;
   assign arready = arready_r;
   assign rvalid = rvalid_r;
   assign rdata = rdata_r;
   assign rresp = rresp_r;
   assign irq = irq_r;
   assign remoteWakeup = wake_r;
   assign sofActive = sofActive_r;
   assign rootHubReset = hubRst_r;
   assign portResetDrive = hubRst_r;

   // -------------------------------------------------------------
   // checks
   // -------------------------------------------------------------
   // cycles spent in the operational state
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         operCnt_r <= '0;
      else if (fs_r != FS_OPERATIONAL)
         operCnt_r <= '0;
      else if (!(&operCnt_r))
         operCnt_r <= operCnt_r + 1'b1;
   end

   chk_wake_signal: assert property (
      @(posedge clk) disable iff (!nrst)
      rwe_r && intSts[INT_RD_BIT] |=> remoteWakeup)
      else $error("remote wake-up not signalled");
   chk_irq_mask_only: assert property (
      @(posedge clk) disable iff (!nrst)
      !(|(intSts & mask_r)) && rwe_r |=> !irq)
      else $error("interrupt raised by wake-up enable");
   chk_rwc_kept: assert property (
      @(posedge clk) disable iff (!nrst)
      swRst |=> rwc_r == $past(rwc_r))
      else $error("wake-up connected lost on software reset");
   chk_fs_hw_change: assert property (
      @(posedge clk) disable iff (!nrst)
      fs_r != $past(fs_r) && !$past(ctrlWr) && !$past(swRst)
      |-> $past(fs_r) == FS_SUSPENDED && fs_r == FS_BUS_RESUME)
      else $error("state changed by hardware outside suspend");
   chk_resume_move: assert property (
      @(posedge clk) disable iff (!nrst)
      fs_r == FS_SUSPENDED && resumeDetect && !ctrlWr && !swRst
      |=> fs_r == FS_BUS_RESUME ##1 intSts[INT_RD_BIT])
      else $error("resume not taken from suspend");
   chk_sof_delay: assert property (
      @(posedge clk) disable iff (!nrst)
      $rose(sofActive) |-> operCnt_r == (CNT_W+1)'(SOF_CYC))
      else $error("frame starts began at wrong delay");
   chk_swrst_state: assert property (
      @(posedge clk) disable iff (!nrst)
      swRst |=> fs_r == FS_BUS_RESET && !rwe_r)
      else $error("software reset missed bus reset state");
   chk_hub_no_swrst: assert property (
      @(posedge clk) disable iff (!nrst)
      !rootHubReset |=> !rootHubReset && !portResetDrive)
      else $error("root hub reset raised after power-up");
   chk_ctrl_read: assert property (
      @(posedge clk) disable iff (!nrst)
      arvalid && arready && araddr == ADDR_CTRL
      |=> rvalid && rresp == RESP_OKAY && (rdata & ~CTRL_MASK) == '0)
      else $error("control read bad response or reserved bits");

endmodule
`default_nettype wire

// file: bench/hcf_top_tb_top.sv
/*
 Self-checking bench for the host operating-control block.
 Assumes hcf_pkg is compiled first and a short frame-start delay.
*/
`timescale 1ns/1ns
`default_nettype none
module hcf_top_tb_top
   import hcf_pkg::*;
;
   // ---------------------------------------------------------------
   // signals and instance
   // ---------------------------------------------------------------
   localparam int SOF = 20;
   localparam int LIMIT = 4000;
   logic clk, nrst, awvalid, wvalid, bready, arvalid, rready;
   logic resumeDetect;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata;
   logic [3:0] wstrb;
   wire logic awready, wready, bvalid, arready, rvalid, irq;
   wire logic remoteWakeup, sofActive, rootHubReset, portResetDrive;
   wire logic [1:0] bresp, rresp;
   wire logic [31:0] rdata;
   logic [31:0] rdq[$];
   logic [1:0] rrq[$];
   logic [1:0] bq[$];
   int failCount = 0;
   int compares = 0;
   int cycles = 0;
   integer seed = 81;
   logic [31:0] v;

   hcf_top #(.SOF_CYC(SOF)) uut
   (
      .clk(clk), .nrst(nrst), .awaddr(awaddr), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
      .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
      .araddr(araddr), .arvalid(arvalid), .arready(arready),
      .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
      .resumeDetect(resumeDetect), .irq(irq),
      .remoteWakeup(remoteWakeup), .sofActive(sofActive),
      .rootHubReset(rootHubReset), .portResetDrive(portResetDrive)
   );

   // clock, 4 ns period
   initial
   begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   // ---------------------------------------------------------------
   // compare and report tasks
   // ---------------------------------------------------------------
   task cmp_word(input logic [31:0] g, input logic [31:0] e,
                 input string m);
      compares++;
      if (g !== e)
      begin
         failCount++;
         $display("BAD %0t %s got %h exp %h", $time, m, g, e);
      end
   endtask

   task cmp_resp(input logic [1:0] g, input logic [1:0] e, input string m);
      cmp_word({30'h0, g}, {30'h0, e}, m);
   endtask

   task cmp_lvl(input logic g, input logic e, input string m);
      cmp_word({31'h0, g}, {31'h0, e}, m);
   endtask

   task end_test(input string m);
      $display("test %s done, %0d mismatches so far", m, failCount);
   endtask

   task print_verdict;
      $display("compares %0d, mismatches %0d", compares, failCount);
      if (failCount == 0 && compares > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // ---------------------------------------------------------------
   // bus master tasks
   // ---------------------------------------------------------------
   task cyc(input int n);
      repeat (n) @(posedge clk);
   endtask

   task axi_write(input logic [7:0] a, input logic [31:0] d,
                  input logic [1:0] er);
      bq.push_back(er);
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do
      begin
         @(posedge clk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid && bready) bready <= 1'b0;
      end
      while (bready);
   endtask

   task axi_read(input logic [7:0] a, input logic [31:0] e,
                 input logic [1:0] er);
      rdq.push_back(e);
      rrq.push_back(er);
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do
      begin
         @(posedge clk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid && rready) rready <= 1'b0;
      end
      while (rready);
   endtask

   task pulse_resume;
      @(posedge clk);
      resumeDetect <= 1'b1;
      @(posedge clk);
      resumeDetect <= 1'b0;
   endtask

   task hw_reset;
      nrst <= 1'b0;
      cyc(10);
      nrst <= 1'b1;
   endtask

   // monitor: match each response against the oldest note
   always @(posedge clk)
   begin
      if (rvalid && rready)
      begin
         if (rdq.size() == 0)
            cmp_word(32'h1, 32'h0, "unexpected read");
         else
         begin
            cmp_word(rdata, rdq.pop_front(), "read data");
            cmp_resp(rresp, rrq.pop_front(), "read resp");
         end
      end
      if (bvalid && bready)
      begin
         if (bq.size() == 0)
            cmp_word(32'h1, 32'h0, "unexpected write resp");
         else
            cmp_resp(bresp, bq.pop_front(), "write resp");
      end
   end

   // watchdog against a hung handshake
   always @(posedge clk)
   begin
      cycles <= cycles + 1;
      if (cycles == LIMIT)
      begin
         failCount++;
         print_verdict;
      end
   end

   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial
   begin
      {nrst, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
      {awaddr, araddr, wdata, wstrb, resumeDetect} = 53'h0;
      wstrb = 4'hF;
      cyc(10);
      nrst <= 1'b1;
      cmp_lvl(rootHubReset, 1'b1, "hub reset");
      axi_read(ADDR_CTRL, 32'h0, RESP_OKAY);
      axi_read(ADDR_STATUS, 32'h4, RESP_OKAY);
      cyc(20);
      cmp_lvl(rootHubReset, 1'b0, "hub release");
      cmp_lvl(portResetDrive, 1'b0, "port release");
      end_test("reset");
      axi_write(ADDR_CTRL, 32'hFFFFFFFF, RESP_OKAY);
      axi_read(ADDR_CTRL, CTRL_MASK, RESP_OKAY);
      for (int i = 0; i < 4; i++)
      begin
         v = ($random(seed) & 32'hFFFFFF3F) | (i << 6);
         axi_write(ADDR_CTRL, v, RESP_OKAY);
         axi_read(ADDR_CTRL, v & CTRL_MASK, RESP_OKAY);
      end
      axi_read(8'h40, 32'h0, RESP_SLVERR);
      axi_write(8'h40, 32'h0, RESP_SLVERR);
      axi_read(ADDR_CTRL, v & CTRL_MASK, RESP_OKAY);
      end_test("fields");
      axi_write(ADDR_CTRL, 32'h0, RESP_OKAY);
      axi_write(ADDR_INTSTS, 32'h3, RESP_OKAY);
      axi_write(ADDR_INTMASK, 32'h0, RESP_OKAY);
      axi_write(ADDR_CTRL, 32'h80, RESP_OKAY);
      cyc(SOF - 2);
      cmp_lvl(sofActive, 1'b0, "frame start early");
      cyc(1);
      cmp_lvl(sofActive, 1'b1, "frame start late");
      pulse_resume;
      axi_read(ADDR_CTRL, 32'h80, RESP_OKAY);
      axi_read(ADDR_INTSTS, 32'h3, RESP_OKAY);
      axi_write(ADDR_CTRL, 32'h0, RESP_OKAY);
      cyc(2);
      cmp_lvl(sofActive, 1'b0, "frame start stop");
      axi_write(ADDR_INTSTS, 32'h3, RESP_OKAY);
      end_test("frame start");
      axi_write(ADDR_CTRL, 32'h4C0, RESP_OKAY);
      pulse_resume;
      cyc(2);
      cmp_lvl(remoteWakeup, 1'b1, "wake on");
      cmp_lvl(irq, 1'b0, "irq masked");
      axi_read(ADDR_CTRL, 32'h440, RESP_OKAY);
      axi_write(ADDR_INTMASK, 32'h1, RESP_OKAY);
      cyc(2);
      cmp_lvl(irq, 1'b1, "irq unmasked");
      axi_write(ADDR_CTRL, 32'h40, RESP_OKAY);
      cyc(2);
      cmp_lvl(remoteWakeup, 1'b0, "wake off");
      cmp_lvl(irq, 1'b1, "irq kept");
      axi_write(ADDR_INTSTS, 32'h1, RESP_OKAY);
      cyc(2);
      cmp_lvl(irq, 1'b0, "irq cleared");
      end_test("wake");
      axi_write(ADDR_CTRL, 32'h680, RESP_OKAY);
      axi_write(ADDR_SWRST, 32'h1, RESP_OKAY);
      axi_read(ADDR_CTRL, 32'h200, RESP_OKAY);
      axi_read(ADDR_SWRST, 32'h0, RESP_OKAY);
      cmp_lvl(rootHubReset, 1'b0, "soft reset hub");
      hw_reset;
      cmp_lvl(portResetDrive, 1'b1, "hard reset port");
      axi_read(ADDR_CTRL, 32'h0, RESP_OKAY);
      axi_read(ADDR_STATUS, 32'h4, RESP_OKAY);
      end_test("resets");
      print_verdict;
   end
endmodule
`default_nettype wire
